// [ebs_select_logic.sv]
`timescale 1ns/1ns
`include "ebs_defines.svh"

module ebs_select_logic #(
   parameter int NUM_CS = 6
) (
   // clock and reset
   input  wire logic                        core_clk,
   input  wire logic                        reset,
   // access request from the bus controller
   input  wire logic                        accessReq,
   input  wire logic [`EBS_INT_ADDR_W-1:0]  accessAddr,
   input  wire logic                        accessWrite,
   input  wire logic                        accessWord,
   input  wire logic                        accessWide,
   input  wire logic                        cycleDone,
   // configuration
   input  wire logic [7:0]                  chip_config_reg_zero,
   input  wire logic [7:0]                  window_select_reg,
   input  wire logic                        holdActive,
   input  wire logic [NUM_CS-1:0]           csWe,
   input  wire logic [`EBS_INT_ADDR_W-1:0]  csBaseIn,
   input  wire logic [`EBS_INT_ADDR_W-1:0]  csTopIn,
   // port 2 configuration writes for the shared pin
   input  wire logic                        portCfgWe,
   input  wire logic                        portFuncIn,
   input  wire logic                        portDirIn,
   input  wire logic                        portValIn,
   // memory routing input
   input  wire logic                        external_access_n,
   // pins
   output logic [`EBS_EXT_ADDR_W-1:0]       ext_addr_lines,
   output logic                             addr_bit_zero,
   output logic                             byte_high_strobe_n,
   output logic                             write_high_strobe_n,
   output logic                             pending_cycle_request_n,
   output logic                             half_rate_clock_out,
   output logic [NUM_CS-1:0]                range_select_n,
   // status
   output logic                             extCycle,
   output logic                             intCycle,
   output logic [2:0]                       cfgSelect,
   output logic                             port2_function_sel,
   output logic                             port2_direction,
   output logic                             port2_output_value
);

   initial begin
      if (NUM_CS != 6) $error("ebs_select_logic: NUM_CS must be 6");
   end

   // ****************************************************
   // chip-select range registers
   // ****************************************************
   logic [`EBS_INT_ADDR_W-1:0] csBase_reg [NUM_CS];
   logic [`EBS_INT_ADDR_W-1:0] csTop_reg  [NUM_CS];
   logic [NUM_CS-1:0]          csHit;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CS; gi++) begin : g_cs
         always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
               csBase_reg[gi] <= (gi == 0) ? `EBS_CS0_RESET_BASE
                                           : `EBS_CS_RESET_BASE;
               csTop_reg[gi]  <= (gi == 0) ? `EBS_CS0_RESET_TOP
                                           : `EBS_CS_RESET_TOP;
            end else if (csWe[gi]) begin
               csBase_reg[gi] <= csBaseIn;
               csTop_reg[gi]  <= csTopIn;
            end
         end
         // empty ranges (base above top) never hit
         assign csHit[gi] = (accessAddr >= csBase_reg[gi]) &&
                            (accessAddr <= csTop_reg[gi]);
      end
   endgenerate

   // ****************************************************
   // decode
   // ****************************************************
   wire inPartition = (accessAddr >= `EBS_PART_LO) &&
                      (accessAddr <= `EBS_PART_HI);
   // live pin level, so routing may change between accesses
   wire goInternal  = inPartition && external_access_n;
   wire goExternal  = accessReq && !goInternal;
   wire bheRole     = chip_config_reg_zero[`EBS_CHIP_CONFIG_REG_ZERO_BHE_BIT];
   wire holdEn      = window_select_reg[`EBS_WSR_HOLD_BIT];

   // lowest-numbered hit wins when ranges overlap
   logic [2:0] hitIdx;
   always_comb begin
      hitIdx = 3'(`EBS_FALLBACK_CS);
      for (int i = NUM_CS - 1; i >= 0; i--) begin
         if (csHit[i]) hitIdx = 3'(i);
      end
   end

   // high byte present on a wide bus: word access, or byte with address bit set
   wire hiByte  = accessWide && (accessWord || accessAddr[0]);
   // byte-high strobe level: low when the high byte is present
   wire bheNext = !(accessWide && (accessWord || accessAddr[0]));
   wire wrhNext = !(hiByte && accessWrite);

   // ****************************************************
   // cycle tracking
   // ****************************************************
   ebs_pkg::ebs_state_t state_reg;
   ebs_pkg::ebs_state_t state_next;
   wire startExt = (state_reg == ebs_pkg::EBS_IDLE) && goExternal &&
                   !holdActive;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ebs_pkg::EBS_IDLE: begin
            if (startExt) state_next = ebs_pkg::EBS_CYCLE;
         end
         ebs_pkg::EBS_CYCLE: begin
            if (cycleDone) state_next = ebs_pkg::EBS_IDLE;
         end
         default: state_next = ebs_pkg::EBS_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) state_reg <= ebs_pkg::EBS_IDLE;
      else       state_reg <= state_next;
   end

   // ****************************************************
   // pin registers
   // ****************************************************
   // pins drop at the cycleDone edge, so the next start may follow at once
   wire inCycleNext = (state_next == ebs_pkg::EBS_CYCLE);
   wire [NUM_CS-1:0] selOneHot = NUM_CS'(1) << hitIdx;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         range_select_n      <= '1;
         byte_high_strobe_n  <= 1'b1;
         write_high_strobe_n <= 1'b1;
         ext_addr_lines      <= '0;
         addr_bit_zero       <= 1'b0;
         cfgSelect           <= 3'(`EBS_FALLBACK_CS);
         extCycle            <= 1'b0;
      end else if (startExt) begin
         ext_addr_lines <= accessAddr[`EBS_EXT_ADDR_W-1:0];
         addr_bit_zero  <= accessAddr[0];
         range_select_n <= (|csHit) ? ~selOneHot : '1;
         cfgSelect      <= hitIdx;
         byte_high_strobe_n  <= bheRole ? bheNext : 1'b1;
         write_high_strobe_n <= bheRole ? 1'b1 : wrhNext;
         extCycle            <= 1'b1;
      end else if (!inCycleNext) begin
         range_select_n      <= '1;
         byte_high_strobe_n  <= 1'b1;
         write_high_strobe_n <= 1'b1;
         extCycle            <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) intCycle <= 1'b0;
      else       intCycle <= accessReq && goInternal;
   end

   // ****************************************************
   // hold request and shared port pin
   // ****************************************************
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) pending_cycle_request_n <= 1'b1;
      else pending_cycle_request_n <=
              !(holdEn && holdActive && goExternal);
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         port2_function_sel <= 1'b0;
         port2_direction    <= 1'b0;
         port2_output_value <= 1'b0;
      end else if (holdEn) begin
         // forced to request function, writes dropped
         port2_function_sel <= 1'b1;
         port2_direction    <= 1'b0;
      end else if (portCfgWe) begin
         port2_function_sel <= portFuncIn;
         port2_direction    <= portDirIn;
         port2_output_value <= portValIn;
      end
   end

   // ****************************************************
   // half-rate clock
   // ****************************************************
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) half_rate_clock_out <= 1'b0;
      else       half_rate_clock_out <= ~half_rate_clock_out;
   end

   // ****************************************************
   // assertions
   // ****************************************************
   a_clk_toggle: assert property (@(posedge core_clk) disable iff (reset)
      !$past(reset) |-> half_rate_clock_out != $past(half_rate_clock_out))
      else $error("half-rate clock did not toggle");

   a_idle_strobes: assert property (@(posedge core_clk) disable iff (reset)
      !extCycle |-> (&range_select_n && byte_high_strobe_n &&
                     write_high_strobe_n))
      else $error("strobe active outside external cycle");

   a_onehot_sel: assert property (@(posedge core_clk) disable iff (reset)
      $countones(~range_select_n) <= 1)
      else $error("more than one select asserted");

   a_start_sel: assert property (@(posedge core_clk) disable iff (reset)
      startExt && csHit == '0 |=> &range_select_n &&
                                  cfgSelect == 3'(`EBS_FALLBACK_CS))
      else $error("fallback select wrong");

   a_bhe_word: assert property (@(posedge core_clk) disable iff (reset)
      startExt && bheRole && accessWide && accessWord
         |=> !byte_high_strobe_n)
      else $error("byte-high strobe missing on word access");

   a_wrh_role: assert property (@(posedge core_clk) disable iff (reset)
      startExt && !bheRole |=> byte_high_strobe_n)
      else $error("byte-high strobe in write-high role");

   a_ea_route: assert property (@(posedge core_clk) disable iff (reset)
      accessReq && inPartition && external_access_n |=> intCycle)
      else $error("partition not routed internally");

   a_pending_cycle_request_n_hold: assert property (@(posedge core_clk) disable iff (reset)
      holdEn && holdActive && goExternal |=> !pending_cycle_request_n)
      else $error("bus request not asserted in hold");

   a_port_lock: assert property (@(posedge core_clk) disable iff (reset)
      holdEn |=> port2_function_sel)
      else $error("shared pin not forced in hold");

   a_sel_index: assert property (@(posedge core_clk) disable iff (reset)
      startExt && |csHit |=> (~range_select_n) == selOneHot)
      else $error("wrong select asserted");

   a_addr_low: assert property (@(posedge core_clk) disable iff (reset)
      startExt |=> ext_addr_lines == $past(accessAddr[`EBS_EXT_ADDR_W-1:0]))
      else $error("external address wrong");

   a_bit_zero: assert property (@(posedge core_clk) disable iff (reset)
      startExt |=> addr_bit_zero == $past(accessAddr[0]))
      else $error("address bit zero wrong");

   a_cs0_reset: assert property (@(posedge core_clk) disable iff (reset)
      $past(reset) |-> csBase_reg[0] == `EBS_CS0_RESET_BASE &&
                       csTop_reg[0] == `EBS_CS0_RESET_TOP)
      else $error("select zero reset range wrong");

   a_hold_nostart: assert property (@(posedge core_clk) disable iff (reset)
      holdActive && !extCycle |=> !extCycle)
      else $error("cycle started while bus held");

   a_int_quiet: assert property (@(posedge core_clk) disable iff (reset)
      accessReq && goInternal && !extCycle |=> !extCycle)
      else $error("internal access drove external cycle");

   a_wrh_write: assert property (@(posedge core_clk) disable iff (reset)
      startExt && !bheRole && hiByte && accessWrite |=> !write_high_strobe_n)
      else $error("write-high strobe missing");

   a_pending_cycle_request_n_idle: assert property (@(posedge core_clk) disable iff (reset)
      !holdEn |=> pending_cycle_request_n)
      else $error("bus request without hold protocol");

   a_dir_lock: assert property (@(posedge core_clk) disable iff (reset)
      holdEn |=> !port2_direction)
      else $error("shared pin direction not forced");

   a_cycle_end: assert property (@(posedge core_clk) disable iff (reset)
      state_reg == ebs_pkg::EBS_CYCLE && cycleDone |=> !extCycle)
      else $error("cycle did not end on done");

endmodule // ebs_select_logic

// [ebs_defines.svh]
`ifndef EBS_DEFINES_SVH
`define EBS_DEFINES_SVH

// ****************************************************
// address map
// ****************************************************
`define EBS_INT_ADDR_W      24
`define EBS_EXT_ADDR_W      20
`define EBS_PART_LO         24'hFF2000
`define EBS_PART_HI         24'hFFDFFF
`define EBS_CS0_RESET_BASE  24'hFF2000
`define EBS_CS0_RESET_TOP   24'hFF20FF
`define EBS_CS_RESET_BASE   24'hFFFFFF
`define EBS_CS_RESET_TOP    24'h000000

// ****************************************************
// configuration bit positions and fallback select index
// ****************************************************
`define EBS_CHIP_CONFIG_REG_ZERO_BHE_BIT    2
`define EBS_WSR_HOLD_BIT    7
`define EBS_FALLBACK_CS     5

`endif

// [ebs_pkg.sv]
package ebs_pkg;
   // role of the shared byte-high / write-high pin
   typedef enum logic {EBS_PIN_WRH, EBS_PIN_BHE} ebs_pin_role_t;
   // external bus cycle phase
   typedef enum logic [1:0] {EBS_IDLE, EBS_CYCLE} ebs_state_t;
endpackage

// [ebs_mem_model.sv]
`timescale 1ns/1ns
// ****************************************************
// external memory: ends each cycle after a set wait
// ****************************************************
module ebs_mem_model (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       reset,
   // cycle in progress and wait length
   input  wire logic       extCycle,
   input  wire logic [3:0] waitCycles,
   // end of cycle
   output logic            cycleDone
);
   logic [3:0] waitCnt;
   // one-cycle pulse, so the cycle never ends twice
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         waitCnt   <= 4'h0;
         cycleDone <= 1'b0;
      end else begin
         cycleDone <= extCycle && !cycleDone && waitCnt == waitCycles;
         waitCnt   <= (extCycle && !cycleDone) ? waitCnt + 4'h1 : 4'h0;
      end
   end
endmodule // ebs_mem_model

// [tb.sv]
`timescale 1ns/1ns
module tb;
   logic        core_clk = 1'b0, reset = 1'b1, accessReq = 1'b0;
   logic        accessWrite = 1'b0, accessWord = 1'b0, accessWide = 1'b1;
   logic        holdActive = 1'b0, portCfgWe = 1'b0, portFuncIn = 1'b0;
   logic        portDirIn = 1'b0, portValIn = 1'b0, external_access_n = 1'b0;
   logic [23:0] accessAddr = 24'h0, csBaseIn = 24'h0, csTopIn = 24'h0;
   logic [7:0]  chip_config_reg_zero = 8'h04, window_select_reg = 8'h00;
   logic [5:0]  csWe = 6'h00, range_select_n;
   logic [3:0]  waitCycles = 4'h0;
   logic [19:0] ext_addr_lines;
   logic [2:0]  cfgSelect;
   logic        cycleDone, addr_bit_zero, byte_high_strobe_n, extCycle;
   logic        write_high_strobe_n, pending_cycle_request_n, intCycle;
   logic        half_rate_clock_out, port2_function_sel, port2_direction;
   logic        port2_output_value, prev;
   int          fail_count = 0, samples_checked = 0;

   always #4 core_clk = ~core_clk;

   ebs_select_logic i_dut (.core_clk, .reset, .accessReq, .accessAddr,
      .accessWrite, .accessWord, .accessWide, .cycleDone,
      .chip_config_reg_zero, .window_select_reg, .holdActive, .csWe,
      .csBaseIn, .csTopIn, .portCfgWe, .portFuncIn, .portDirIn, .portValIn,
      .external_access_n, .ext_addr_lines, .addr_bit_zero,
      .byte_high_strobe_n, .write_high_strobe_n, .pending_cycle_request_n,
      .half_rate_clock_out, .range_select_n, .extCycle, .intCycle,
      .cfgSelect, .port2_function_sel, .port2_direction,
      .port2_output_value);
   ebs_mem_model i_mem (.core_clk, .reset, .extCycle, .waitCycles,
      .cycleDone);

   // ****************************************************
   // checking and access tasks
   // ****************************************************
   task automatic check(string nm, logic [23:0] seen, logic [23:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // entered and left just after a rising edge
   task automatic access(logic [23:0] a, logic wd, logic wr,
                         logic [5:0] sel, logic bhe, logic wrh);
      int n;
      accessAddr = a;
      accessWord = wd;
      accessWrite = wr;
      accessReq = 1'b1;
      @(posedge core_clk) #1;
      accessReq = 1'b0;
      check("ext cycle", extCycle, 1'b1);
      check("select", range_select_n, sel);
      check("byte high", byte_high_strobe_n, bhe);
      check("write high", write_high_strobe_n, wrh);
      check("addr bit", addr_bit_zero, a[0]);
      check("ext addr", ext_addr_lines, a[19:0]);
      n = 0;
      while (extCycle === 1'b1 && n < 40) begin
         @(posedge core_clk) #1;
         n++;
      end
      if (n == 40) begin
         fail_count++;
         stop_test();
      end
      check("idle select", range_select_n, 6'h3F);
      check("idle strobe", byte_high_strobe_n, 1'b1);
   endtask

   // ****************************************************
   // test sequence
   // ****************************************************
   initial begin
      repeat (10) @(posedge core_clk);
      #1 reset = 1'b0;
      check("reset select", range_select_n, 6'h3F);
      check("reset cfg", cfgSelect, 3'h5);
      prev = half_rate_clock_out;
      repeat (4) begin
         @(posedge core_clk) #1;
         check("clock out", half_rate_clock_out, !prev);
         prev = half_rate_clock_out;
      end
      $display("test clock done");
      access(24'hFF2010, 1'b1, 1'b0, 6'h3E, 1'b0, 1'b1);
      waitCycles = 4'h5;
      access(24'hFF2011, 1'b0, 1'b1, 6'h3E, 1'b0, 1'b1);
      access(24'hFF2020, 1'b0, 1'b0, 6'h3E, 1'b1, 1'b1);
      access(24'hFF2100, 1'b1, 1'b0, 6'h3F, 1'b0, 1'b1);
      chip_config_reg_zero = 8'h00;
      access(24'hFF2011, 1'b0, 1'b1, 6'h3E, 1'b1, 1'b0);
      access(24'hFF2030, 1'b0, 1'b1, 6'h3E, 1'b1, 1'b1);
      chip_config_reg_zero = 8'h04;
      $display("test strobes done");
      // internal routing leaves the pins quiet
      external_access_n = 1'b1;
      accessAddr = 24'hFF2010;
      accessReq = 1'b1;
      @(posedge core_clk) #1;
      accessReq = 1'b0;
      check("int cycle", extCycle, 1'b0);
      check("int select", range_select_n, 6'h3F);
      repeat (2) @(posedge core_clk);
      #1 csWe = 6'h02;
      csBaseIn = 24'h010000;
      csTopIn = 24'h01FFFF;
      @(posedge core_clk) #1 csWe = 6'h00;
      access(24'h012345, 1'b0, 1'b0, 6'h3D, 1'b0, 1'b1);
      check("cfg index", cfgSelect, 3'h1);
      access(24'h020000, 1'b1, 1'b0, 6'h3F, 1'b0, 1'b1);
      check("cfg fallback", cfgSelect, 3'h5);
      external_access_n = 1'b0;
      access(24'hFF2010, 1'b1, 1'b0, 6'h3E, 1'b0, 1'b1);
      $display("test routing done");
      window_select_reg = 8'h80;
      holdActive = 1'b1;
      accessAddr = 24'hFF2010;
      accessReq = 1'b1;
      repeat (2) @(posedge core_clk);
      #1 check("request", pending_cycle_request_n, 1'b0);
      check("held cycle", extCycle, 1'b0);
      portFuncIn = 1'b0;
      portCfgWe = 1'b1;
      @(posedge core_clk) #1 portCfgWe = 1'b0;
      check("pin func", port2_function_sel, 1'b1);
      holdActive = 1'b0;
      access(24'hFF2010, 1'b1, 1'b0, 6'h3E, 1'b0, 1'b1);
      window_select_reg = 8'h00;
      $display("test hold done");
      stop_test();
   end
endmodule // tb
